// >>> rtl/dgc_pkg.sv
// Package for the converter update timing and general counter block.
// Assumes a 20 MHz system clock and an APB register slave.
package dgc_pkg;
   localparam int unsigned DGC_CLK_HZ = 20000000;
   localparam int unsigned DGC_FIX_HZ = 2000000;
   localparam int unsigned DGC_FIX_DIV = DGC_CLK_HZ / DGC_FIX_HZ;
   localparam logic [7:0] DGC_A_CTRL = 8'h00;
   localparam logic [7:0] DGC_A_STAT = 8'h04;
   localparam logic [7:0] DGC_A_DAC0 = 8'h08;
   localparam logic [7:0] DGC_A_DAC1 = 8'h0c;
   localparam logic [7:0] DGC_A_IVAL = 8'h10;
   localparam logic [7:0] DGC_A_CMODE = 8'h14;
   localparam logic [7:0] DGC_A_CNT0 = 8'h18;
   localparam int unsigned DGC_CTRL_DLY0 = 0;
   localparam int unsigned DGC_CTRL_DLY1 = 1;
   localparam int unsigned DGC_CTRL_INT = 2;
   localparam int unsigned DGC_CTRL_IVEN = 3;
   localparam int unsigned DGC_M_FALL = 0;
   localparam int unsigned DGC_M_GATE = 1;
   localparam int unsigned DGC_M_EDGE = 2;
   localparam int unsigned DGC_DAC_W = 12;
   localparam int unsigned DGC_CNT_W = 16;
   localparam int unsigned DGC_NCNT = 3;
   localparam logic [15:0] DGC_CNT_RST = 16'hffff;
   typedef enum logic [2:0]
   {
      DGC_IDLE = 3'b001,
      DGC_SETUP = 3'b010,
      DGC_ACC = 3'b100
   } dgc_apb_t;
endpackage

// >>> rtl/dgc_top.sv
// Converter update timing and three general 16-bit down counters.
// Assumes an APB master on clk_sys_in; pins are asynchronous.
//
// Summary of operation
// - Interval counter times converter loads internally.
// - External update strobe may time loads instead.
// - Immediate mode updates output on write.
// - Delayed mode holds value until update event.
// - Strobe rising edge raises update interrupt.
// - Strobe is level sensitive during writes.
// - Converters load while output-load signal high.
// - Counter zero clocked from fixed 2 MHz.
// - Counters 1 and 2 count chosen edge, counter 0 every 2 MHz tick; value readable.
// - Gate suspends and resumes event counting.
// - Level gating counts down only gate high.
// - Edge gating starts count after gate rise.
// - Frequency mode counts falling edges while gated.
// - Gate sampled, output changed on clock rise.
// - Three 16-bit counters plus 8-bit mode register.
`timescale 1ns/1ns
`default_nettype none
module dgc_top
   import dgc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic ext_output_load_n_in,
   input wire logic [DGC_NCNT-1:1] cnt_clk_in,
   input wire logic [DGC_NCNT-1:0] cnt_gate_in,
   output logic [DGC_NCNT-1:0] cnt_out,
   output logic [DGC_DAC_W-1:0] dac0_out,
   output logic [DGC_DAC_W-1:0] dac1_out,
   output logic update_irq_out
);
   // ----------------------------------------------------------------
   // Synchronisers.
   // ----------------------------------------------------------------
   logic [2:0] ld_sync_reg;
   logic [DGC_NCNT-1:1] clk_s1_reg, clk_s2_reg, clk_s3_reg;
   logic [DGC_NCNT-1:0] gate_s1_reg, gate_s2_reg;
   // Pins idle high through pull-ups, so every stage resets high to avoid a false edge.
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         ld_sync_reg <= '1;
      else
         ld_sync_reg <= {ld_sync_reg[1:0], ext_output_load_n_in};
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         clk_s1_reg <= '1;
         clk_s2_reg <= '1;
         clk_s3_reg <= '1;
      end
      else
      begin
         clk_s1_reg <= cnt_clk_in;
         clk_s2_reg <= clk_s1_reg;
         clk_s3_reg <= clk_s2_reg;
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         gate_s1_reg <= '1;
         gate_s2_reg <= '1;
      end
      else
      begin
         gate_s1_reg <= cnt_gate_in;
         gate_s2_reg <= gate_s1_reg;
      end
   end
   wire logic ld_low = !ld_sync_reg[1];
   wire logic ld_rise = ld_sync_reg[1] && !ld_sync_reg[2];

   // ----------------------------------------------------------------
   // Fixed 2 MHz enable.
   // ----------------------------------------------------------------
   logic [7:0] div_reg;
   logic fix_en_reg, fix_ph_reg;
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         div_reg <= '0;
         fix_en_reg <= 1'b0;
         fix_ph_reg <= 1'b0;
      end
      else
      begin
         fix_en_reg <= (div_reg == 8'(DGC_FIX_DIV - 1));
         div_reg <= (div_reg == 8'(DGC_FIX_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
         if (div_reg == 8'(DGC_FIX_DIV / 2 - 1) || div_reg == 8'(DGC_FIX_DIV - 1))
            fix_ph_reg <= !fix_ph_reg;
      end
   end

   // ----------------------------------------------------------------
   // APB slave.
   // ----------------------------------------------------------------
   dgc_apb_t st_reg;
   logic [3:0] ctrl_reg;
   logic [DGC_DAC_W-1:0] hold0_reg, hold1_reg;
   logic [DGC_CNT_W-1:0] ival_reg, ival_cnt_reg;
   logic [7:0] cmode_reg;
   logic [DGC_CNT_W-1:0] load_reg [DGC_NCNT];
   logic [DGC_CNT_W-1:0] cnt_reg [DGC_NCNT];
   logic [DGC_NCNT-1:0] cnt_ld_reg;
   logic wr0_reg, wr1_reg, irq_clr_reg;
   wire logic acc = psel_in && penable_in;
   wire logic wr = acc && pwrite_in;
   wire logic cnt_hit = paddr_in >= DGC_A_CNT0 &&
                        paddr_in < 8'(DGC_A_CNT0 + 4 * DGC_NCNT) && paddr_in[1:0] == 2'b00;
   wire logic [1:0] cnt_idx = 2'((paddr_in - DGC_A_CNT0) >> 2);
   wire logic hit = cnt_hit || paddr_in == DGC_A_CTRL || paddr_in == DGC_A_STAT ||
                    paddr_in == DGC_A_DAC0 || paddr_in == DGC_A_DAC1 ||
                    paddr_in == DGC_A_IVAL || paddr_in == DGC_A_CMODE;
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         st_reg <= DGC_IDLE;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= '0;
      end
      else
      begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         case (st_reg)
            DGC_IDLE: if (psel_in && !penable_in) st_reg <= DGC_SETUP;
            DGC_SETUP:
            begin
               st_reg <= DGC_ACC;
               pready_out <= 1'b1;
               pslverr_out <= !hit;
               prdata_out <= '0;
               if (cnt_hit)
                  prdata_out <= 32'(cnt_reg[cnt_idx]);
               else if (paddr_in == DGC_A_CTRL)
                  prdata_out <= 32'(ctrl_reg);
               else if (paddr_in == DGC_A_STAT)
                  prdata_out <= {30'h0, ld_low, update_irq_out};
               else if (paddr_in == DGC_A_DAC0)
                  prdata_out <= 32'(hold0_reg);
               else if (paddr_in == DGC_A_DAC1)
                  prdata_out <= 32'(hold1_reg);
               else if (paddr_in == DGC_A_IVAL)
                  prdata_out <= 32'(ival_reg);
               else if (paddr_in == DGC_A_CMODE)
                  prdata_out <= 32'(cmode_reg);
            end
            DGC_ACC: st_reg <= (psel_in && !penable_in) ? DGC_SETUP : DGC_IDLE;
            default: st_reg <= DGC_IDLE;
         endcase
      end
   end
   wire logic wr_take = wr && pready_out;

   // ----------------------------------------------------------------
   // Register writes.
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         ctrl_reg <= '0;
         hold0_reg <= '0;
         hold1_reg <= '0;
         ival_reg <= DGC_CNT_RST;
         cmode_reg <= '0;
      end
      else if (wr_take)
      begin
         if (paddr_in == DGC_A_CTRL) ctrl_reg <= pwdata_in[3:0];
         if (paddr_in == DGC_A_DAC0) hold0_reg <= pwdata_in[DGC_DAC_W-1:0];
         if (paddr_in == DGC_A_DAC1) hold1_reg <= pwdata_in[DGC_DAC_W-1:0];
         if (paddr_in == DGC_A_IVAL) ival_reg <= pwdata_in[DGC_CNT_W-1:0];
         if (paddr_in == DGC_A_CMODE) cmode_reg <= pwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         wr0_reg <= 1'b0;
         wr1_reg <= 1'b0;
         irq_clr_reg <= 1'b0;
      end
      else
      begin
         wr0_reg <= wr_take && paddr_in == DGC_A_DAC0;
         wr1_reg <= wr_take && paddr_in == DGC_A_DAC1;
         irq_clr_reg <= wr_take && paddr_in == DGC_A_STAT && pwdata_in[0];
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         cnt_ld_reg <= '0;
         for (int i = 0; i < DGC_NCNT; i++) load_reg[i] <= DGC_CNT_RST;
      end
      else
      begin
         cnt_ld_reg <= '0;
         if (wr_take && cnt_hit)
         begin
            load_reg[cnt_idx] <= pwdata_in[DGC_CNT_W-1:0];
            cnt_ld_reg[cnt_idx] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Converter update path.
   // ----------------------------------------------------------------
   logic ival_tick_reg;
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         ival_cnt_reg <= DGC_CNT_RST;
         ival_tick_reg <= 1'b0;
      end
      else
      begin
         ival_tick_reg <= 1'b0;
         if (ctrl_reg[DGC_CTRL_IVEN] && fix_en_reg)
         begin
            if (ival_cnt_reg == '0)
            begin
               ival_cnt_reg <= ival_reg;
               ival_tick_reg <= 1'b1;
            end
            else
               ival_cnt_reg <= ival_cnt_reg - 16'h0001;
         end
         else if (!ctrl_reg[DGC_CTRL_IVEN])
            ival_cnt_reg <= ival_reg;
      end
   end
   // Output-load signal: level of the strobe or an interval tick.
   wire logic out_load = (!ctrl_reg[DGC_CTRL_INT] && ld_low) ||
                         (ctrl_reg[DGC_CTRL_INT] && ival_tick_reg);
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         dac0_out <= '0;
         dac1_out <= '0;
      end
      else
      begin
         if (!ctrl_reg[DGC_CTRL_DLY0] ? wr0_reg : out_load)
            dac0_out <= hold0_reg;
         if (!ctrl_reg[DGC_CTRL_DLY1] ? wr1_reg : out_load)
            dac1_out <= hold1_reg;
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         update_irq_out <= 1'b0;
      else if (ld_rise)
         update_irq_out <= 1'b1;
      else if (irq_clr_reg)
         update_irq_out <= 1'b0;
   end

   // ----------------------------------------------------------------
   // General counters.
   // ----------------------------------------------------------------
   logic [DGC_NCNT-1:0] gate_d_reg, armed_reg;
   genvar g;
   generate
      for (g = 0; g < DGC_NCNT; g++)
      begin : g_cnt
         logic ck_now, ck_old, tick, g_ok;
         if (g == 0)
         begin : g_fix
            assign ck_now = fix_ph_reg;
            assign ck_old = !fix_ph_reg;
            assign tick = fix_en_reg;
         end
         else
         begin : g_ext
            assign ck_now = clk_s2_reg[g];
            assign ck_old = clk_s3_reg[g];
            assign tick = 1'b0;
         end
         wire logic rise = (g == 0) ? tick : (ck_now && !ck_old);
         wire logic fall = (g == 0) ? tick : (!ck_now && ck_old);
         wire logic edg = cmode_reg[g*2 + DGC_M_FALL] ? fall : rise;
         wire logic [1:0] md = cmode_reg[g*2+1 -: 2];
         assign g_ok = md[1] ? armed_reg[g] : (!md[0] || gate_s2_reg[g]);
         always_ff @(posedge clk_sys_in)
         begin
            if (!reset_n_in)
            begin
               cnt_reg[g] <= DGC_CNT_RST;
               gate_d_reg[g] <= 1'b1;
               armed_reg[g] <= 1'b0;
               cnt_out[g] <= 1'b0;
            end
            else
            begin
               if (rise)
               begin
                  gate_d_reg[g] <= gate_s2_reg[g];
                  if (gate_s2_reg[g] && !gate_d_reg[g]) armed_reg[g] <= 1'b1;
                  cnt_out[g] <= cnt_reg[g] == '0;
               end
               if (cnt_ld_reg[g])
               begin
                  cnt_reg[g] <= load_reg[g];
                  armed_reg[g] <= 1'b0;
               end
               else if (edg && g_ok)
                  cnt_reg[g] <= cnt_reg[g] - 16'h0001;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> dv/dgc_checker.sv
// Assertions on the ports of the converter update and counter block.
// Assumes a bind to dgc_top in the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module dgc_checker
   import dgc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic ext_output_load_n_in,
   input wire logic [DGC_NCNT-1:1] cnt_clk_in,
   input wire logic [DGC_NCNT-1:0] cnt_gate_in,
   input wire logic [DGC_NCNT-1:0] cnt_out,
   input wire logic [DGC_DAC_W-1:0] dac0_out,
   input wire logic [DGC_DAC_W-1:0] dac1_out,
   input wire logic update_irq_out
);
   // ------------------------------------------------------------
   // Helper logic and assertions
   // ------------------------------------------------------------
   logic wdone;
   logic [3:0] ctrl_reg;
   logic [3:0] quiet_reg;
   logic [DGC_DAC_W-1:0] exp0_reg, exp1_reg;
   logic clr_seen_reg;
   assign wdone = psel_in && penable_in && pready_out && pwrite_in;
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         ctrl_reg <= 4'h0;
      else if (wdone && paddr_in == DGC_A_CTRL)
         ctrl_reg <= pwdata_in[3:0];
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in || !ext_output_load_n_in || !ctrl_reg[0] || ctrl_reg[2])
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf)
         quiet_reg <= quiet_reg + 4'h1;
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         exp0_reg <= '0;
         exp1_reg <= '0;
         clr_seen_reg <= 1'b0;
      end
      else
      begin
         clr_seen_reg <= wdone && paddr_in == DGC_A_STAT && pwdata_in[0];
         if (wdone && paddr_in == DGC_A_DAC0)
            exp0_reg <= pwdata_in[DGC_DAC_W-1:0];
         if (wdone && paddr_in == DGC_A_DAC1)
            exp1_reg <= pwdata_in[DGC_DAC_W-1:0];
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   property p_imm;
      wdone && paddr_in == DGC_A_DAC0 && !ctrl_reg[0]
         |-> ##[1:3] dac0_out == exp0_reg;
   endproperty
   property p_level;
      wdone && paddr_in == DGC_A_DAC1 && !ctrl_reg[2] && !ext_output_load_n_in
         && !$past(ext_output_load_n_in, 4) |-> ##[1:4] dac1_out == exp1_reg;
   endproperty
   AST_ANSWER: assert property (psel_in && !penable_in |-> ##2 pready_out)
      else $error("no answer two cycles after setup");
   AST_ONE_CYCLE: assert property (pready_out |=> !pready_out)
      else $error("ready held longer than one cycle");
   AST_UNMAPPED: assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
      else $error("refused read returned data");
   AST_IMMEDIATE: assert property (p_imm)
      else $error("immediate write did not reach output");
   AST_HOLD: assert property (quiet_reg > 4'h4 |-> $stable(dac0_out))
      else $error("delayed output changed without update");
   AST_IRQ_SET: assert property ($rose(ext_output_load_n_in) |-> ##[1:4] update_irq_out)
      else $error("strobe rise raised no interrupt");
   AST_IRQ_HOLD: assert property (update_irq_out && !clr_seen_reg |=> update_irq_out)
      else $error("interrupt dropped without clear");
   AST_LEVEL: assert property (p_level)
      else $error("write under low strobe not loaded");
   COV_IRQ: cover property ($rose(update_irq_out));
   COV_REFUSE: cover property (pready_out && pslverr_out);
   COV_HOLD: cover property (quiet_reg > 4'h8);
endmodule
`default_nettype wire

// >>> dv/dgc_ext_model.sv
// Model of the external update strobe and counter clock and gate sources.
// Assumes the testbench calls its tasks; lines idle high like pulled-up pins.
`timescale 1ns/1ns
`default_nettype none
module dgc_ext_model
(
   input wire logic clk_in,
   output logic load_n_out,
   output logic [2:1] cnt_clk_out,
   output logic [2:0] cnt_gate_out
);
   // ------------------------------------------------------------
   // Drivers
   // ------------------------------------------------------------
   initial
   begin
      load_n_out = 1'b1;
      cnt_clk_out = 2'b11;
      cnt_gate_out = 3'b111;
   end
   task automatic set_load(input logic lvl);
      @(posedge clk_in);
      load_n_out <= lvl;
   endtask
   task automatic pulse(input int lo);
      set_load(1'b0);
      repeat (lo) @(posedge clk_in);
      load_n_out <= 1'b1;
   endtask
   task automatic edges(input int idx, input int cnt);
      repeat (cnt)
      begin
         repeat (4) @(posedge clk_in);
         cnt_clk_out[idx] <= 1'b0;
         repeat (4) @(posedge clk_in);
         cnt_clk_out[idx] <= 1'b1;
      end
      repeat (6) @(posedge clk_in);
   endtask
   task automatic gate(input int idx, input logic lvl);
      @(posedge clk_in);
      cnt_gate_out[idx] <= lvl;
   endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking testbench for the converter update and counter block.
// Assumes dgc_top, dgc_checker and dgc_ext_model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import dgc_pkg::*;
;
   // ------------------------------------------------------------
   // Signals, tasks and sequence
   // ------------------------------------------------------------
   logic clk_sys_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic ext_output_load_n_in, update_irq_out, e;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, q, v, n, k;
   logic [2:1] cnt_clk_in;
   logic [2:0] cnt_gate_in, cnt_out;
   logic [11:0] dac0_out, dac1_out;
   int err_count, total_checks;
   dgc_top u_dgc_top (.clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ext_output_load_n_in, .cnt_clk_in,
      .cnt_gate_in, .cnt_out, .dac0_out, .dac1_out, .update_irq_out);
   dgc_ext_model u_dgc_ext_model (.clk_in(clk_sys_in), .load_n_out(ext_output_load_n_in),
      .cnt_clk_out(cnt_clk_in), .cnt_gate_out(cnt_gate_in));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys_in);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk_sys_in);
         i++;
      end
      while (pready_out !== 1'b1 && i < 20);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (i >= 20)
      begin
         err_count++;
         complete_run();
      end
   endtask
   initial
   begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   initial
   begin
      {reset_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      err_count = 0;
      total_checks = 0;
      v = $urandom(32'hee41d041);
      cyc(2);
      reset_n_in <= 1'b1;
      apb(0, DGC_A_CNT0 + 8'h04, 0);
      chk("cnt1 reset", {16'h0, DGC_CNT_RST}, q);
      apb(0, 8'h40, 0);
      chk("unmapped read", 32'h1, {q[30:0], e});
      v = $urandom & 32'hfff;
      apb(1, DGC_A_DAC0, v);
      cyc(4);
      chk("dac0 immediate", v, {20'h0, dac0_out});
      $display("test reset and immediate done");
      n = v;
      apb(1, DGC_A_CTRL, 32'h3);
      v = $urandom & 32'hfff;
      apb(1, DGC_A_DAC0, v);
      cyc(10);
      chk("dac0 held", n, {20'h0, dac0_out});
      u_dgc_ext_model.pulse(3);
      cyc(6);
      chk("dac0 strobe", v, {20'h0, dac0_out});
      chk("irq set", 1, {31'h0, update_irq_out});
      apb(1, DGC_A_STAT, 1);
      cyc(2);
      chk("irq clear", 0, {31'h0, update_irq_out});
      u_dgc_ext_model.set_load(1'b0);
      cyc(6);
      v = $urandom & 32'hfff;
      apb(1, DGC_A_DAC1, v);
      cyc(6);
      chk("dac1 level", v, {20'h0, dac1_out});
      u_dgc_ext_model.set_load(1'b1);
      cyc(6);
      apb(0, DGC_A_STAT, 0);
      chk("stat irq", 1, q & 32'h1);
      $display("test strobe done");
      apb(1, DGC_A_IVAL, 3);
      apb(1, DGC_A_CTRL, 32'hf);
      v = $urandom & 32'hfff;
      apb(1, DGC_A_DAC0, v);
      cyc(60);
      chk("dac0 interval", v, {20'h0, dac0_out});
      repeat (2)
      begin
         apb(1, DGC_A_CMODE, 32'h10);
         n = 100 + $urandom % 900;
         k = 1 + $urandom % 12;
         apb(1, DGC_A_CNT0 + 8'h04, n);
         u_dgc_ext_model.edges(1, k);
         apb(0, DGC_A_CNT0 + 8'h04, 0);
         chk("cnt1 rising", n - k, q);
         u_dgc_ext_model.gate(2, 1'b0);
         apb(1, DGC_A_CNT0 + 8'h08, n);
         u_dgc_ext_model.edges(2, 3);
         u_dgc_ext_model.gate(2, 1'b1);
         u_dgc_ext_model.edges(2, k);
         apb(0, DGC_A_CNT0 + 8'h08, 0);
         chk("cnt2 gated", n - k, q);
      end
      apb(1, DGC_A_CMODE, 32'h08);
      n = 100 + $urandom % 900;
      k = 1 + $urandom % 12;
      u_dgc_ext_model.gate(1, 1'b0);
      apb(1, DGC_A_CNT0 + 8'h04, n);
      u_dgc_ext_model.edges(1, 3);
      u_dgc_ext_model.gate(1, 1'b1);
      u_dgc_ext_model.edges(1, k);
      apb(0, DGC_A_CNT0 + 8'h04, 0);
      chk("cnt1 edge gated", n - k + 1, q);
      apb(1, DGC_A_CMODE, 32'h0);
      apb(1, DGC_A_CNT0 + 8'h04, k);
      u_dgc_ext_model.edges(1, k);
      chk("cnt1 out before zero", 0, {31'h0, cnt_out[1]});
      u_dgc_ext_model.edges(1, 1);
      chk("cnt1 out at zero", 1, {31'h0, cnt_out[1]});
      apb(1, DGC_A_CNT0, 1000);
      cyc(200);
      apb(0, DGC_A_CNT0, 0);
      chk("cnt0 fixed clock", 1, {31'h0, q >= 977 && q <= 983});
      $display("test counters done");
      complete_run();
   end
endmodule
bind dgc_top dgc_checker u_dgc_checker (.clk_sys_in, .reset_n_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .ext_output_load_n_in, .cnt_clk_in, .cnt_gate_in, .cnt_out, .dac0_out, .dac1_out,
   .update_irq_out);
`default_nettype wire
